/* File: core/agr_record_cmd.sv */
// Purpose: Record command handler for one gateway, two segments
// Assumes: Request header then payload, one byte per valid cycle
// Notes:   One request in flight; answer ends with resp_last
`timescale 1ns/1ps
`default_nettype none
module agr_record_cmd
   import agr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // Request header
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic [7:0]  req_func,
   input  wire logic [7:0]  req_index,
   input  wire logic [7:0]  req_slot,
   input  wire logic [7:0]  req_subslot,
   // Write payload
   input  wire logic        wr_valid,
   input  wire logic [7:0]  wr_byte,
   // Response stream
   output logic             resp_valid,
   output logic [7:0]       resp_data,
   output logic             resp_last,
   output logic             resp_ok,
   // Segment state in
   input  wire logic [63:0] seg1_node_map,
   input  wire logic [63:0] seg2_node_map,
   input  wire logic [1:0]  offline_ready,
   input  wire logic [1:0]  periphery_power_fault,
   input  wire logic [1:0]  config_ok,
   input  wire logic [1:0]  auto_addr_available,
   input  wire logic [1:0]  auto_addr_assign,
   input  wire logic [1:0]  data_exchange_done,
   input  wire logic [1:0]  periphery_ok,
   input  wire logic [1:0]  readdress_ok,
   // Segment control out
   output logic [1:0]       config_mode,
   output logic [1:0]       offline_mode,
   output logic [1:0]       data_exchange_off,
   output logic [1:0]       auto_addr_enable,
   output logic [1:0]       readdress_strobe,
   output logic [5:0]       readdress_old,
   output logic [5:0]       readdress_new
);
   agr_state_type state;
   logic [7:0] func;
   logic       seg;
   logic       hdr_ok;
   logic [3:0] pos;
   logic [7:0] b2;
   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   wire slot_ok  = (req_slot == SLOT_SEG1) || (req_slot == SLOT_SEG2);
   wire addr_ok  = slot_ok && req_index == REQ_INDEX && req_subslot == SUBSLOT_REC;
   wire take     = req_valid && req_ready;
   wire rd_func  = (req_func == IDX_NODE_LIST) || (req_func == IDX_FLAGS);
   wire wr_func  = (req_func >= IDX_OP_MODE) && (req_func <= IDX_AUTO_ADDR);
   wire func_ok  = req_write ? wr_func : rd_func;
   wire wr_step  = (state == AGR_WDATA) && wr_valid;
   wire wr_end   = wr_step && pos == WR_LAST;
   wire hdr_byte = (pos == 4'h0) || (pos == 4'h1);
   wire next_hdr_ok = hdr_ok && !(wr_step && hdr_byte && wr_byte != 8'h00);
   wire [7:0] rd_last = (func == IDX_NODE_LIST) ? {4'h0, NODE_STAT_BYTE} : {4'h0, FLAG_LAST};
   wire rd_end   = (state == AGR_RDATA) && pos == rd_last[3:0];
   wire flag_sel = (func == IDX_OP_MODE) || (func == IDX_OFFLINE) ||
                   (func == IDX_DATA_EXCH) || (func == IDX_AUTO_ADDR);
   wire flag_clean = (b2[7:1] == 7'h00);
   wire apply   = wr_end && next_hdr_ok && (!flag_sel || flag_clean);
   wire [63:0] seg_map = seg ? seg2_node_map : seg1_node_map;
   // Bit 0 of byte 2 and of byte 6 carry no node
   wire [63:0] map_out = {seg_map[63:33], 1'b0, seg_map[31:1], 1'b0};
   wire [15:0] flag_word = {offline_ready[seg], periphery_power_fault[seg],
                            ~config_mode[seg] & ~offline_mode[seg], config_mode[seg],
                            auto_addr_available[seg], auto_addr_assign[seg],
                            ~seg_map[0], config_ok[seg],
                            5'b00000, offline_mode[seg],
                            ~data_exchange_off[seg] & data_exchange_done[seg],
                            periphery_ok[seg]};
   wire [7:0]  rbyte;
   agr_resp_byte agr_resp_byte_i (
      .func_index         (func),
      .byte_pos           (pos),
      .status_ok          (hdr_ok),
      .detected_node_list (map_out),
      .flag_word          (flag_word),
      .resp_byte          (rbyte)
   );
   assign req_ready = (state == AGR_IDLE);
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= AGR_IDLE;
         func <= 8'h00;
         seg <= 1'b0;
         hdr_ok <= 1'b0;
         pos <= 4'h0;
         b2 <= 8'h00;
         resp_valid <= 1'b0;
         resp_data <= 8'h00;
         resp_last <= 1'b0;
         resp_ok <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         resp_last <= 1'b0;
         unique case (state)
            AGR_IDLE: begin
               pos <= 4'h0;
               if (take) begin
                  func <= req_func;
                  seg <= (req_slot == SLOT_SEG2);
                  hdr_ok <= addr_ok && func_ok;
                  state <= req_write ? AGR_WDATA : AGR_RDATA;
               end
            end
            AGR_WDATA: begin
               if (wr_step) begin
                  hdr_ok <= next_hdr_ok;
                  pos <= pos + 4'h1;
                  if (pos == 4'h2)
                     b2 <= wr_byte;
                  if (wr_end) begin
                     resp_valid <= 1'b1;
                     resp_last <= 1'b1;
                     resp_ok <= apply;
                     resp_data <= apply ? STAT_OK : STAT_NOK;
                     state <= AGR_IDLE;
                  end
               end
            end
            AGR_RDATA: begin
               resp_valid <= 1'b1;
               resp_data <= hdr_ok ? rbyte : 8'h00;
               pos <= pos + 4'h1;
               if (rd_end) begin
                  resp_data <= hdr_ok ? rbyte : STAT_NOK;
                  resp_last <= 1'b1;
                  resp_ok <= hdr_ok;
                  state <= AGR_DONE;
               end
            end
            AGR_DONE: state <= AGR_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // Segment controls
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_seg
         wire hit = apply && (seg == g);
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               config_mode[g] <= 1'b0;
               offline_mode[g] <= 1'b0;
               data_exchange_off[g] <= 1'b0;
               auto_addr_enable[g] <= 1'b0;
               readdress_strobe[g] <= 1'b0;
            end else begin
               readdress_strobe[g] <= hit && func == IDX_READDRESS;
               if (hit && func == IDX_OP_MODE)
                  config_mode[g] <= b2[0];
               if (hit && func == IDX_OFFLINE)
                  offline_mode[g] <= b2[0];
               if (hit && func == IDX_DATA_EXCH)
                  data_exchange_off[g] <= b2[0];
               if (hit && func == IDX_AUTO_ADDR)
                  auto_addr_enable[g] <= b2[0];
            end
         end
      end
   endgenerate
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         readdress_old <= 6'h00;
         readdress_new <= 6'h00;
      end else if (apply && func == IDX_READDRESS) begin
         readdress_old <= b2[5:0];
         readdress_new <= wr_byte[5:0];
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_wr_end;
      wr_end;
   endsequence
   chk_wr_status: assert property (@(posedge ref_clk) disable iff (!reset_n)
      s_wr_end |=> resp_valid && resp_last && (resp_ok == (resp_data == STAT_OK)))
      else $error("write status missing");
   chk_bad_slot: assert property (@(posedge ref_clk) disable iff (!reset_n)
      take && !slot_ok && req_write |=> !hdr_ok)
      else $error("bad slot accepted");
   chk_cfg_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
      apply && func == IDX_OP_MODE |=> config_mode[seg] == $past(b2[0]))
      else $error("operation mode not applied");
   chk_offline: assert property (@(posedge ref_clk) disable iff (!reset_n)
      apply && func == IDX_OFFLINE |=> offline_mode[seg] == $past(b2[0]))
      else $error("offline mode not applied");
   chk_dx_inv: assert property (@(posedge ref_clk) disable iff (!reset_n)
      apply && func == IDX_DATA_EXCH |=> data_exchange_off[seg] == $past(b2[0]))
      else $error("data exchange flag wrong");
   chk_auto_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      apply && func == IDX_AUTO_ADDR |=> auto_addr_enable[seg] == $past(b2[0]))
      else $error("auto address flag wrong");
   chk_readdr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      apply && func == IDX_READDRESS |=> readdress_strobe[seg] &&
      readdress_new == $past(wr_byte[5:0]))
      else $error("readdress not issued");
   chk_map_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
      take && !req_write && req_func == IDX_NODE_LIST |=> ##12 resp_last)
      else $error("node list length wrong");
   chk_flag_len: assert property (@(posedge ref_clk) disable iff (!reset_n)
      take && !req_write && req_func == IDX_FLAGS |=> ##4 resp_last)
      else $error("flag response length wrong");
endmodule
`default_nettype wire

/* File: core/agr_resp_byte.sv */
// Purpose: Selects one read-response byte by position
// Assumes: Node map and flags are stable during a read
// Notes:   Pure decode, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module agr_resp_byte
   import agr_pkg::*;
(
   // Selection
   input  wire logic [7:0]  func_index,
   input  wire logic [3:0]  byte_pos,
   input  wire logic        status_ok,
   // Segment state
   input  wire logic [63:0] detected_node_list,
   input  wire logic [15:0] flag_word,
   // Result
   output logic [7:0]       resp_byte
);
   wire        is_map   = (func_index == IDX_NODE_LIST);
   wire        in_map   = (byte_pos >= MAP_FIRST) && (byte_pos <= MAP_LAST);
   wire [2:0]  map_sel  = 3'(byte_pos - MAP_FIRST);
   wire [7:0]  map_byte = detected_node_list[{map_sel, 3'b000} +: 8];
   wire [7:0]  stat     = status_ok ? STAT_OK : STAT_NOK;
   assign resp_byte =
      (is_map && in_map) ? map_byte :
      (is_map && byte_pos == NODE_STAT_BYTE) ? stat :
      (!is_map && byte_pos == 4'h2) ? flag_word[15:8] :
      (!is_map && byte_pos == 4'h3) ? flag_word[7:0] :
      8'h00;
endmodule
`default_nettype wire

/* File: pkg/agr_pkg.sv */
// Purpose: Constants for the acyclic record command handler
// Assumes: Payload bytes arrive one per cycle, byte 0 first
// Notes:   Functional notes below
//
// Functional notes
// - Index 0x0F reads node bitmap, status byte 11
// - Bitmap bytes 2..9, bit 0 of bytes 2 and 6 unused
// - Index 0x10 reads segment master flags
// - Flag bytes 2 and 3 carry fixed bit layout
// - Index 0x11 write selects operation mode
// - Selector 0 protected, 1 configuration mode
// - Index 0x12 write selects offline mode
// - Selector 0 online, 1 offline
// - Index 0x13 write controls data exchange
// - Inverted flag: 1 disables data exchange
// - Index 0x14 write requests node readdressing
// - Bytes 2,3 old/new address, bit5 half-node
// - Index 0x15 write sets automatic addressing
// - Flag 0 disables, 1 enables auto addressing
// - Write status OK if applied, else NOK
package agr_pkg;
   localparam logic [7:0] IDX_NODE_LIST  = 8'h0F;
   localparam logic [7:0] IDX_FLAGS      = 8'h10;
   localparam logic [7:0] IDX_OP_MODE    = 8'h11;
   localparam logic [7:0] IDX_OFFLINE    = 8'h12;
   localparam logic [7:0] IDX_DATA_EXCH  = 8'h13;
   localparam logic [7:0] IDX_READDRESS  = 8'h14;
   localparam logic [7:0] IDX_AUTO_ADDR  = 8'h15;
   localparam logic [7:0] SLOT_SEG1      = 8'h00;
   localparam logic [7:0] SLOT_SEG2      = 8'h64;
   localparam logic [7:0] SUBSLOT_REC    = 8'h01;
   localparam logic [7:0] REQ_INDEX      = 8'h01;
   localparam logic [3:0] MAP_FIRST      = 4'h2;
   localparam logic [3:0] MAP_LAST       = 4'h9;
   localparam logic [3:0] NODE_STAT_BYTE = 4'hB;
   localparam logic [3:0] FLAG_LAST      = 4'h3;
   localparam logic [3:0] WR_LAST        = 4'h3;
   localparam logic [7:0] STAT_OK        = 8'h00;
   localparam logic [7:0] STAT_NOK       = 8'hFF;
   localparam int         ADDR_HALF_BIT  = 5;
   typedef enum logic [1:0] {AGR_IDLE, AGR_WDATA, AGR_RDATA, AGR_DONE} agr_state_type;
endpackage

/* File: verification/agr_ctrl_model.sv */
// Purpose: Controller model issuing record requests
// Assumes: Lines change at the falling edge only
// Notes:   Released func, slot and byte lines show the inverted last value
`timescale 1ns/1ps
`default_nettype none
module agr_ctrl_model
   import agr_pkg::*;
(
   // Clock
   input  wire logic       ref_clk,
   // Request
   input  wire logic       req_ready,
   output logic            req_valid,
   output logic            req_write,
   output logic [7:0]      req_func,
   output logic [7:0]      req_index,
   output logic [7:0]      req_slot,
   output logic [7:0]      req_subslot,
   output logic            wr_valid,
   output logic [7:0]      wr_byte,
   // Response
   input  wire logic       resp_valid,
   input  wire logic [7:0] resp_data,
   input  wire logic       resp_last,
   input  wire logic       resp_ok
);
   logic [7:0] rx [0:11];
   logic       ok_seen;
   logic       timed_out;
   initial begin
      timed_out = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_func = 8'h00;
      req_index = 8'h00;
      req_slot = 8'h00;
      req_subslot = 8'h00;
      wr_valid = 1'b0;
      wr_byte = 8'h00;
   end
   // ----------------------------------------
   // One request, payload, then answer
   // ----------------------------------------
   task automatic run(input logic wr, input logic [7:0] func, slot, b2, b3);
      int i;
      int n;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_func = func;
      req_index = REQ_INDEX;
      req_slot = slot;
      req_subslot = SUBSLOT_REC;
      i = 0;
      while (req_ready !== 1'b1 && i < 50) begin
         @(negedge ref_clk);
         i++;
      end
      if (i == 50) timed_out = 1'b1;
      @(negedge ref_clk);
      req_valid = 1'b0;
      req_func = ~req_func;
      req_slot = ~req_slot;
      if (wr) begin
         for (int k = 0; k < 4; k++) begin
            wr_valid = 1'b1;
            wr_byte = (k == 2) ? b2 : (k == 3) ? b3 : 8'h00;
            @(negedge ref_clk);
         end
         wr_valid = 1'b0;
         wr_byte = ~wr_byte;
      end
      n = 0;
      for (i = 0; i < 40; i++) begin
         if (resp_valid === 1'b1 && n < 12) begin
            rx[n] = resp_data;
            n++;
            if (resp_last === 1'b1) begin
               ok_seen = resp_ok;
               break;
            end
         end
         @(negedge ref_clk);
      end
      if (i == 40) timed_out = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: verification/agr_record_cmd_test.sv */
// Purpose: Self-checking bench for the record command handler
// Assumes: Inputs change at the falling edge
// Notes:   Segment state driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module agr_record_cmd_test;
   import agr_pkg::*;
   logic ref_clk, reset_n, req_ready, req_valid, req_write, wr_valid;
   logic resp_valid, resp_last, resp_ok;
   logic [7:0] req_func, req_index, req_slot, req_subslot, wr_byte, resp_data;
   logic [63:0] map1, map2;
   logic [1:0] o_rdy, ppf, c_ok, aa_av, aa_as, dx_done, p_ok;
   logic [1:0] cfg, offl, dx_off, aa_en, rd_stb;
   logic [5:0] rd_old, rd_new;
   int failures, checks_done;
   agr_record_cmd agr_record_cmd_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_func(req_func), .req_index(req_index), .req_slot(req_slot),
      .req_subslot(req_subslot), .wr_valid(wr_valid), .wr_byte(wr_byte),
      .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
      .resp_ok(resp_ok), .seg1_node_map(map1), .seg2_node_map(map2),
      .offline_ready(o_rdy), .periphery_power_fault(ppf), .config_ok(c_ok),
      .auto_addr_available(aa_av), .auto_addr_assign(aa_as),
      .data_exchange_done(dx_done), .periphery_ok(p_ok), .readdress_ok(2'b00),
      .config_mode(cfg), .offline_mode(offl), .data_exchange_off(dx_off),
      .auto_addr_enable(aa_en), .readdress_strobe(rd_stb),
      .readdress_old(rd_old), .readdress_new(rd_new));
   agr_ctrl_model agr_ctrl_model_i (.ref_clk(ref_clk), .req_ready(req_ready),
      .req_valid(req_valid), .req_write(req_write), .req_func(req_func),
      .req_index(req_index), .req_slot(req_slot), .req_subslot(req_subslot),
      .wr_valid(wr_valid), .wr_byte(wr_byte), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_last(resp_last), .resp_ok(resp_ok));
   // ----------------------------------------
   // Clock
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("failures %0d checks_done %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic go(input logic wr, input logic [7:0] f, s, b2, b3);
      agr_ctrl_model_i.run(wr, f, s, b2, b3);
      if (agr_ctrl_model_i.timed_out) begin
         failures++;
         report_and_stop;
      end
   endtask
   function automatic logic [1:0] ctl(input logic [7:0] f);
      case (f)
         IDX_OP_MODE:   ctl = cfg;
         IDX_OFFLINE:   ctl = offl;
         IDX_DATA_EXCH: ctl = dx_off;
         default:       ctl = aa_en;
      endcase
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reads;
      logic [7:0] exp2;
      exp2 = {o_rdy[0], ppf[0], 2'b10, aa_av[0], aa_as[0], ~map1[0], c_ok[0]};
      go(1'b0, IDX_FLAGS, SLOT_SEG1, 8'h00, 8'h00);
      check("flags2", agr_ctrl_model_i.rx[2], exp2);
      exp2 = {5'h00, 1'b0, dx_done[0], p_ok[0]};
      check("flags3", agr_ctrl_model_i.rx[3], exp2);
      go(1'b0, IDX_NODE_LIST, SLOT_SEG2, 8'h00, 8'h00);
      for (int k = 2; k < 10; k++) begin
         exp2 = map2[8*(k-2)+:8] & ((k == 2 || k == 6) ? 8'hFE : 8'hFF);
         check("map", agr_ctrl_model_i.rx[k], exp2);
      end
      check("map0", agr_ctrl_model_i.rx[0], 8'h00);
      check("map10", agr_ctrl_model_i.rx[10], 8'h00);
      check("mapstat", agr_ctrl_model_i.rx[11], STAT_OK);
   endtask
   task automatic t_flag_writes;
      logic [7:0] fl [0:3];
      fl = '{IDX_OP_MODE, IDX_OFFLINE, IDX_DATA_EXCH, IDX_AUTO_ADDR};
      for (int k = 0; k < 8; k++) begin
         go(1'b1, fl[k%4], (k%2) ? SLOT_SEG2 : SLOT_SEG1, {7'h00, k < 4}, 8'h00);
         check("ctl", {6'h00, ctl(fl[k%4])}, (k < 4) ? 8'h01 << (k%2) : 8'h00);
         check("wstat", agr_ctrl_model_i.rx[0], STAT_OK);
      end
   endtask
   task automatic t_readdress_and_refusals;
      go(1'b1, IDX_READDRESS, SLOT_SEG2, 8'h25, 8'h1F);
      check("rd_stat", agr_ctrl_model_i.rx[0], STAT_OK);
      check("rd_stb", {6'h00, rd_stb}, 8'h02);
      check("rd_old", {2'b00, rd_old}, 8'h25);
      check("rd_new", {2'b00, rd_new}, 8'h1F);
      @(negedge ref_clk);
      check("rd_pulse", {6'h00, rd_stb}, 8'h00);
      go(1'b1, IDX_OP_MODE, 8'h05, 8'h01, 8'h00);
      check("badslot", agr_ctrl_model_i.rx[0], STAT_NOK);
      check("cfgkept", {6'h00, cfg}, 8'h00);
      go(1'b1, IDX_OFFLINE, SLOT_SEG1, 8'h03, 8'h00);
      check("badbits", {7'h00, agr_ctrl_model_i.ok_seen}, 8'h00);
      check("offkept", {6'h00, offl}, 8'h00);
   endtask
   task automatic t_reset_and_bad_read;
      @(negedge ref_clk);
      reset_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b1;
      check("rst_old", {2'b00, rd_old}, 8'h00);
      check("rst_rdy", {7'h00, req_ready}, 8'h01);
      go(1'b0, IDX_FLAGS, 8'h05, 8'h00, 8'h00);
      check("badrd2", agr_ctrl_model_i.rx[2], 8'h00);
      check("badrd3", agr_ctrl_model_i.rx[3], STAT_NOK);
      check("badrdok", {7'h00, agr_ctrl_model_i.ok_seen}, 8'h00);
   endtask
   initial begin
      failures = 0;
      checks_done = 0;
      reset_n = 1'b0;
      map1 = 64'h0000_0000_0000_0000;
      map2 = 64'h0123_4567_89AB_CDEF;
      {o_rdy, ppf, c_ok, aa_av, aa_as, dx_done, p_ok} = 14'h3C3F;
      repeat (12) @(negedge ref_clk);
      reset_n = 1'b1;
      t_reads;
      t_flag_writes;
      t_readdress_and_refusals;
      t_reset_and_bad_read;
      report_and_stop;
   end
endmodule
`default_nettype wire
